/* include/fnvc_pkg.sv */
// Purpose: shared constants and types for the nonvolatile config one block
// Assumes: 10 MHz CLK, byte-wide register command port
// Notes:   bit positions, reset value and write-time counts live here
package fnvc_pkg;
   // ------------------------------------------------------------
   // register layout
   // ------------------------------------------------------------
   localparam logic [7:0] FNVC_RESET        = 8'h00;
   localparam int         FNVC_POS_ORIGIN   = 5;
   localparam int         FNVC_POS_SOURCE   = 3;
   localparam int         FNVC_POS_PARAM    = 2;
   localparam int         FNVC_POS_QUAD     = 1;
   localparam int         FNVC_POS_FREEZE   = 0;
   localparam logic [7:0] FNVC_OTP_MASK     = 8'h2c;
   localparam logic [7:0] FNVC_VALID_MASK   = 8'h2f;
   localparam logic [2:0] FNVC_BP_ALL       = 3'h7;
   // command codes
   localparam logic [7:0] FNVC_CMD_WRR      = 8'h01;
   localparam logic [7:0] FNVC_CMD_WRITE_ANY_REGISTER_CMD     = 8'h71;
   localparam logic [7:0] FNVC_CMD_READ_ANY_REGISTER_CMD     = 8'h65;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int FNVC_CLK_MHZ        = 10;
   localparam int FNVC_NV_WRITE_US    = 200;  // nonvolatile write time
   localparam int FNVC_V_WRITE_NS     = 50;   // volatile write time
   localparam int FNVC_NV_CYCLES      = FNVC_NV_WRITE_US * FNVC_CLK_MHZ;
   localparam int FNVC_V_CYCLES_RAW   = (FNVC_V_WRITE_NS * FNVC_CLK_MHZ + 999) / 1000;
   localparam int FNVC_V_CYCLES       = (FNVC_V_CYCLES_RAW < 1) ? 1 : FNVC_V_CYCLES_RAW;
   localparam int FNVC_CNT_W          = 12;
   // write request carrier
   typedef struct packed {
      logic       write_registers_cmd;      // write-registers, one cycle
      logic       write_any_register_cmd;     // write-any-register
      logic [7:0] data;
   } fnvc_wr_t;
   typedef enum logic [1:0] {
      FNVC_IDLE    = 2'b00,
      FNVC_BUSY_V  = 2'b01,
      FNVC_BUSY_NV = 2'b11
   } fnvc_state_t;
endpackage : fnvc_pkg

/* verilog/fnvc_timer.sv */
// Purpose: one-shot countdown that times a register write
// Assumes: load and count on the same clock
// Notes:   done is a one-cycle pulse when the count runs out
`timescale 1ns/1ns
module fnvc_timer
   import fnvc_pkg::*;
(
   input  wire logic                  CLK,
   input  wire logic                  RST_N,
   input  wire logic                  load,
   input  wire logic [FNVC_CNT_W-1:0] count,
   output logic                       done
);
   logic [FNVC_CNT_W-1:0] remain;
   wire                   running = (remain != '0);
   // ------------------------------------------------------------
   // countdown
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         remain <= '0;
         done   <= 1'b0;
      end
      else
      begin
         done <= running && (remain == FNVC_CNT_W'(1));
         if (load)
            remain <= count;
         else if (running)
            remain <= remain - FNVC_CNT_W'(1);
      end
   end
endmodule : fnvc_timer

/* verilog/fnvc_config_one.sv */
// Purpose: nonvolatile protection and interface config register, byte one
// Assumes: command decoder hands over whole write bytes with the wel check
// Notes:   freeze default has no write path; it keeps its reset value of zero
`timescale 1ns/1ns
// Summary of operation
// - write-registers/any-register and nonvolatile four-lane mode change; read-any reads back
// - eight bits reset zero; 7,6,4 reserved
// - origin bit: 0 top, 1 bottom protection
// - otp bits never return to zero, no error
// - source zero: nonvolatile levels, long write
// - source set programs nonvolatile levels to 111
// - source one: volatile levels only, short write
// - parameter bit one top, zero bottom
// - parameter bit ignored with uniform sectors
// - origin and parameter bits independent
// - quad default writable, not carried in the volatile copy
// - nonvolatile four-lane mode forces quad default
// - four-lane mode active blocks quad clear
// - freeze default read only, seeds freeze; FREEZE here is a separate input, not loaded from it
// - volatile copies track nonvolatile otp bits
// - freeze holds protection bits, no error
module fnvc_config_one
   import fnvc_pkg::*;
(
   input  wire logic     CLK,
   input  wire logic     RST_N,
   input  wire fnvc_wr_t WR_REQ,           // one-cycle write strobe with byte
   input  wire logic     WRITE_ENABLE_LATCH,
   input  wire logic     RD_REQ,           // read-any-register strobe
   input  wire logic     FOUR_LANE_NV_SET, // nonvolatile four-lane mode programmed
   input  wire logic     FOUR_LANE_COMMAND_MODE,
   input  wire logic     FREEZE,           // volatile freeze bit
   input  wire logic     UNIFORM_SECTORS,
   input  wire logic [2:0] BP_LEVEL_IN,    // new block protect level with the write
   output logic [7:0]    NONVOLATILE_PROTECTION_INTERFACE_CONFIG,
   output logic [7:0]    VOLATILE_COPY,
   output logic [7:0]    RD_DATA,
   output logic          RD_VALID,
   output logic [2:0]    BLOCK_PROTECT_LEVEL_NONVOLATILE,
   output logic [2:0]    BLOCK_PROTECT_LEVEL,
   output logic          PROTECT_FROM_BOTTOM,
   output logic          PARAM_AT_TOP,
   output logic          PARAM_AT_BOTTOM,
   output logic          BUSY,
   output logic          WRITE_DONE
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0]  cfg;
   logic [2:0]  block_protect_level_nonvolatile;
   logic [2:0]  bp_v;
   fnvc_state_t state;
   logic        pend_wrr;
   logic [7:0]  pend_data;
   logic [2:0]  pend_bp;
   logic        timer_done;
   // ------------------------------------------------------------
   // write decode
   // ------------------------------------------------------------
   // write enable gate
   wire accept     = (WR_REQ.write_registers_cmd || WR_REQ.write_any_register_cmd) && WRITE_ENABLE_LATCH && (state == FNVC_IDLE);
   wire source_vol = cfg[FNVC_POS_SOURCE];
   wire [7:0] wr_clean = pend_data & FNVC_VALID_MASK;
   wire [7:0] otp_next = (cfg | wr_clean) & FNVC_OTP_MASK;
   wire [7:0] prot_next = FREEZE ? (cfg & FNVC_OTP_MASK) : otp_next;
   // quad written, clear refused in four-lane mode
   wire quad_req  = wr_clean[FNVC_POS_QUAD];
   wire quad_next = quad_req || FOUR_LANE_COMMAND_MODE || FOUR_LANE_NV_SET;
   wire [7:0] next_cfg = prot_next
                       | ({7'h00, quad_next} << FNVC_POS_QUAD)
                       | {7'h00, cfg[FNVC_POS_FREEZE]};
   // source turning on forces nonvolatile levels to all ones
   wire source_rise = next_cfg[FNVC_POS_SOURCE] && !source_vol;
   wire nv_write = !source_vol;
   wire [FNVC_CNT_W-1:0] wr_cycles = nv_write ? FNVC_CNT_W'(FNVC_NV_CYCLES)
                                              : FNVC_CNT_W'(FNVC_V_CYCLES);
   // ------------------------------------------------------------
   // write timer
   // ------------------------------------------------------------
   fnvc_timer u_timer (
      .CLK   (CLK),
      .RST_N (RST_N),
      .load  (accept),
      .count (wr_cycles),
      .done  (timer_done)
   );
   // ------------------------------------------------------------
   // capture request and sequence
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state     <= FNVC_IDLE;
         pend_wrr  <= 1'b0;
         pend_data <= 8'h00;
         pend_bp   <= 3'h0;
      end
      else if (accept)
      begin
         state     <= nv_write ? FNVC_BUSY_NV : FNVC_BUSY_V;
         pend_wrr  <= WR_REQ.write_registers_cmd;
         pend_data <= WR_REQ.data;
         pend_bp   <= BP_LEVEL_IN;
      end
      else if (timer_done)
         state <= FNVC_IDLE;
   end
   // ------------------------------------------------------------
   // register commit at end of write time
   // ------------------------------------------------------------
   // commanded writes and nonvolatile four-lane mode change contents, zero reset
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         cfg <= FNVC_RESET;
      else if (timer_done)
         cfg <= next_cfg;
      else if (FOUR_LANE_NV_SET)
         // four-lane mode pulls quad default up
         cfg[FNVC_POS_QUAD] <= 1'b1;
   end
   // block protect levels
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         block_protect_level_nonvolatile <= 3'h0;
         bp_v  <= 3'h0;
      end
      else if (timer_done)
      begin
         if (source_rise && !FREEZE)
         begin
            block_protect_level_nonvolatile <= FNVC_BP_ALL;
            bp_v  <= pend_wrr ? pend_bp : bp_v;
         end
         else if (pend_wrr && !FREEZE)
         begin
            if (nv_write)
               block_protect_level_nonvolatile <= pend_bp;
            bp_v <= pend_bp;
         end
      end
   end
   // ------------------------------------------------------------
   // outputs, all registered
   // ------------------------------------------------------------
   // volatile copies follow; decoded per bit
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         NONVOLATILE_PROTECTION_INTERFACE_CONFIG <= FNVC_RESET;
         VOLATILE_COPY                    <= FNVC_RESET;
         BLOCK_PROTECT_LEVEL_NONVOLATILE  <= 3'h0;
         BLOCK_PROTECT_LEVEL              <= 3'h0;
         PROTECT_FROM_BOTTOM              <= 1'b0;
         PARAM_AT_TOP                     <= 1'b0;
         PARAM_AT_BOTTOM                  <= 1'b0;
         BUSY                             <= 1'b0;
         WRITE_DONE                       <= 1'b0;
         RD_DATA                          <= 8'h00;
         RD_VALID                         <= 1'b0;
      end
      else
      begin
         NONVOLATILE_PROTECTION_INTERFACE_CONFIG <= cfg;
         VOLATILE_COPY                    <= cfg & FNVC_OTP_MASK;
         BLOCK_PROTECT_LEVEL_NONVOLATILE  <= block_protect_level_nonvolatile;
         BLOCK_PROTECT_LEVEL              <= source_vol ? bp_v : block_protect_level_nonvolatile;
         PROTECT_FROM_BOTTOM              <= cfg[FNVC_POS_ORIGIN];
         PARAM_AT_TOP      <= !UNIFORM_SECTORS && cfg[FNVC_POS_PARAM];
         PARAM_AT_BOTTOM   <= !UNIFORM_SECTORS && !cfg[FNVC_POS_PARAM];
         BUSY              <= accept || (state != FNVC_IDLE && !timer_done);
         WRITE_DONE        <= timer_done;
         RD_VALID          <= RD_REQ;
         if (RD_REQ)
            RD_DATA <= cfg & FNVC_VALID_MASK;
      end
   end
endmodule : fnvc_config_one

/* testbench/fnvc_config_one_chk.sv */
// Purpose: port checks of the config one register
// Assumes: one CLK domain, RST_N async low
// Notes:   watches design inputs and outputs only
`timescale 1ns/1ns
module fnvc_config_one_chk
   import fnvc_pkg::*;
(
   input wire logic       CLK,
   input wire logic       RST_N,
   input wire fnvc_wr_t   WR_REQ,
   input wire logic       WRITE_ENABLE_LATCH,
   input wire logic       RD_REQ,
   input wire logic       FOUR_LANE_NV_SET,
   input wire logic       FOUR_LANE_COMMAND_MODE,
   input wire logic       FREEZE,
   input wire logic       UNIFORM_SECTORS,
   input wire logic [2:0] BP_LEVEL_IN,
   input wire logic [7:0] NONVOLATILE_PROTECTION_INTERFACE_CONFIG,
   input wire logic [7:0] VOLATILE_COPY,
   input wire logic [7:0] RD_DATA,
   input wire logic       RD_VALID,
   input wire logic [2:0] BLOCK_PROTECT_LEVEL_NONVOLATILE,
   input wire logic [2:0] BLOCK_PROTECT_LEVEL,
   input wire logic       PROTECT_FROM_BOTTOM,
   input wire logic       PARAM_AT_TOP,
   input wire logic       PARAM_AT_BOTTOM,
   input wire logic       BUSY,
   input wire logic       WRITE_DONE
);
   // ------------------------------------------------------------
   // write timing and field relations
   // ------------------------------------------------------------
   wire logic [7:0] cfg = NONVOLATILE_PROTECTION_INTERFACE_CONFIG;
   // done lands two cycles past the timer span: registered timer done, then the pulse on the commit edge
   localparam int NV_DONE_AT = FNVC_NV_CYCLES + 2;
   wire logic take_nv = WR_REQ.write_registers_cmd && WRITE_ENABLE_LATCH && !BUSY && !cfg[FNVC_POS_SOURCE];
   int nv_age;
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   // long-write age; the span is too long for a delay range
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         nv_age <= 0;
      else if (take_nv)
         nv_age <= 1;
      else if (WRITE_DONE)
         nv_age <= 0;
      else if (nv_age != 0)
         nv_age <= nv_age + 1;
   end
   // a write-registers write taken while idle, split by protection source
   sequence nv_take;
      WR_REQ.write_registers_cmd && WRITE_ENABLE_LATCH && !BUSY && !cfg[FNVC_POS_SOURCE];
   endsequence
   sequence v_take;
      WR_REQ.write_registers_cmd && WRITE_ENABLE_LATCH && !BUSY && cfg[FNVC_POS_SOURCE];
   endsequence
   a_nv_write_time: assert property (nv_take |=> BUSY[*8])
      else $error("nonvolatile write not busy");
   a_nv_done_count: assert property (nv_age != 0
      |-> (WRITE_DONE == (nv_age == NV_DONE_AT)) && (BUSY == !WRITE_DONE))
      else $error("nonvolatile write time off");
   a_v_write_time: assert property (v_take |-> ##[2:4] WRITE_DONE)
      else $error("volatile write time off");
   a_reserved_zero: assert property ((cfg & ~FNVC_VALID_MASK) == 8'h00)
      else $error("reserved bit set");
   a_otp_sticky: assert property (1'b1 |=> ($past(cfg) & FNVC_OTP_MASK & ~cfg) == 8'h00)
      else $error("one-time bit cleared");
   a_copy_tracks: assert property (VOLATILE_COPY == (cfg & FNVC_OTP_MASK))
      else $error("volatile copy differs");
   a_read_back: assert property (RD_REQ |=> RD_VALID && RD_DATA == cfg)
      else $error("read data wrong");
   a_freeze_holds: assert property (FREEZE && !BUSY |=> $stable(cfg & FNVC_OTP_MASK)
      && $stable(BLOCK_PROTECT_LEVEL))
      else $error("frozen bits changed");
   a_quad_held: assert property (FOUR_LANE_COMMAND_MODE && cfg[FNVC_POS_QUAD]
      |=> cfg[FNVC_POS_QUAD])
      else $error("quad default cleared");
   a_source_bp_all: assert property ($rose(cfg[FNVC_POS_SOURCE])
      |-> ##[0:1] BLOCK_PROTECT_LEVEL_NONVOLATILE == FNVC_BP_ALL)
      else $error("levels not all set");
   a_origin_map: assert property ($rose(cfg[FNVC_POS_ORIGIN]) |-> ##[0:1] PROTECT_FROM_BOTTOM)
      else $error("origin not applied");
   a_param_map: assert property (PARAM_AT_TOP |-> cfg[FNVC_POS_PARAM]
      && !$past(UNIFORM_SECTORS))
      else $error("parameter place wrong");
endmodule : fnvc_config_one_chk

/* testbench/fnvc_host.sv */
// Purpose: host issuing register writes and reads
// Assumes: requests launched at falling CLK
// Notes:   released data and level lines show the inverse of the last value; strobes and latch drop to zero
`timescale 1ns/1ns
module fnvc_host
   import fnvc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       write_done,
   input  wire logic       rd_valid,
   input  wire logic [7:0] rd_data,
   output fnvc_wr_t        wr_req,
   output logic            write_enable_latch,
   output logic            rd_req,
   output logic [2:0]      bp_level
);
   int n;
   initial
   begin
      wr_req   = '0;
      write_enable_latch      = 1'b0;
      rd_req   = 1'b0;
      bp_level = 3'h0;
   end
   // latch set just for this write, settings chosen up front
   task automatic wr(input logic any, input logic [7:0] d, input logic [2:0] bp,
                     input logic en);
      @(negedge clk);
      write_enable_latch      = en;
      wr_req   = '{~any, any, d};
      bp_level = bp;
      @(negedge clk);
      wr_req   = '{1'b0, 1'b0, ~d};
      bp_level = ~bp;
      write_enable_latch      = 1'b0;
      n        = 0;
      // bounded wait so a lost done cannot hang the host
      while (en && !write_done && n < 3000)
      begin
         @(negedge clk);
         n++;
      end
      repeat (2) @(negedge clk);
   endtask : wr
   task automatic rd(output logic [7:0] v, output logic ok);
      @(negedge clk);
      rd_req = 1'b1;
      @(negedge clk);
      rd_req = 1'b0;
      v      = rd_data;
      ok     = rd_valid;
   endtask : rd
endmodule : fnvc_host

/* testbench/test_fnvc_config_one.sv */
// Purpose: directed test of the config one register
// Assumes: 100 ns CLK, host model drives the write port
// Notes:   three long writes, watchdog sized well past them
`timescale 1ns/1ns
module test_fnvc_config_one
   import fnvc_pkg::*;
;
   logic CLK = 1'b0, RST_N = 1'b0, RD_REQ, WRITE_ENABLE_LATCH, RD_VALID, BUSY, WRITE_DONE;
   logic FOUR_LANE_NV_SET = 1'b0, FOUR_LANE_COMMAND_MODE = 1'b0;
   logic FREEZE = 1'b0, UNIFORM_SECTORS = 1'b0, PROTECT_FROM_BOTTOM, PARAM_AT_TOP;
   logic PARAM_AT_BOTTOM, ok;
   logic [2:0] BP_LEVEL_IN, BLOCK_PROTECT_LEVEL_NONVOLATILE, BLOCK_PROTECT_LEVEL;
   logic [7:0] NONVOLATILE_PROTECTION_INTERFACE_CONFIG, VOLATILE_COPY, RD_DATA, v;
   fnvc_wr_t   WR_REQ;
   int         err_total = 0;
   int         tests_run = 0;
   wire logic [7:0] cfg = NONVOLATILE_PROTECTION_INTERFACE_CONFIG;
   fnvc_config_one fnvc_config_one_inst (.*);
   fnvc_host fnvc_host_inst (.clk(CLK), .write_done(WRITE_DONE), .rd_valid(RD_VALID),
      .rd_data(RD_DATA), .wr_req(WR_REQ), .write_enable_latch(WRITE_ENABLE_LATCH), .rd_req(RD_REQ),
      .bp_level(BP_LEVEL_IN));
   always #50 CLK = ~CLK;
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   // -----------------------------------------
   // directed sequence
   // -----------------------------------------
   initial
   begin
      repeat (6) @(negedge CLK);
      RST_N = 1'b1;
      @(negedge CLK);
      chk("config", cfg, FNVC_RESET);
      chk("param bottom", {7'h0, PARAM_AT_BOTTOM}, 8'h01);
      fnvc_host_inst.wr(1'b0, 8'hd2, 3'h5, 1'b0);
      chk("config", cfg, 8'h00);
      fnvc_host_inst.wr(1'b0, 8'hd2, 3'h5, 1'b1);
      chk("config", cfg, 8'h02);
      chk("level nv", {5'h0, BLOCK_PROTECT_LEVEL_NONVOLATILE}, 8'h05);
      fnvc_host_inst.rd(v, ok);
      chk("read", v, 8'h02);
      chk("read valid", {7'h0, ok}, 8'h01);
      fnvc_host_inst.wr(1'b0, 8'h20, 3'h5, 1'b1);
      chk("from bottom", {6'h0, PROTECT_FROM_BOTTOM, PARAM_AT_BOTTOM}, 8'h03);
      fnvc_host_inst.wr(1'b0, 8'h0d, 3'h2, 1'b1);
      chk("config", cfg, 8'h2c);
      chk("copy", VOLATILE_COPY, 8'h2c);
      chk("level nv", {5'h0, BLOCK_PROTECT_LEVEL_NONVOLATILE}, 8'h07);
      chk("param top", {7'h0, PARAM_AT_TOP}, 8'h01);
      fnvc_host_inst.wr(1'b0, 8'h00, 3'h3, 1'b1);
      chk("config", cfg, 8'h2c);
      chk("levels", {BLOCK_PROTECT_LEVEL_NONVOLATILE, BLOCK_PROTECT_LEVEL}, 8'h3b);
      $display("test writes done");
      FOUR_LANE_COMMAND_MODE = 1'b1;
      fnvc_host_inst.wr(1'b1, 8'h2e, 3'h0, 1'b1);
      fnvc_host_inst.wr(1'b1, 8'h2c, 3'h0, 1'b1);
      chk("quad held", cfg, 8'h2e);
      FOUR_LANE_COMMAND_MODE = 1'b0;
      fnvc_host_inst.wr(1'b1, 8'h2c, 3'h0, 1'b1);
      chk("quad cleared", cfg, 8'h2c);
      FOUR_LANE_NV_SET = 1'b1;
      fnvc_host_inst.wr(1'b1, 8'h2c, 3'h0, 1'b1);
      chk("quad forced", cfg, 8'h2e);
      FOUR_LANE_NV_SET = 1'b0;
      $display("test quad done");
      FREEZE = 1'b1;
      fnvc_host_inst.wr(1'b0, 8'h2c, 3'h6, 1'b1);
      chk("frozen level", {5'h0, BLOCK_PROTECT_LEVEL}, 8'h03);
      chk("frozen config", cfg, 8'h2c);
      UNIFORM_SECTORS = 1'b1;
      repeat (2) @(negedge CLK);
      chk("uniform", {6'h0, PARAM_AT_TOP, PARAM_AT_BOTTOM}, 8'h00);
      $display("test freeze done");
      stop_test();
   end
   // watchdog: over six times the span of all long writes
   initial
   begin
      #(40000 * 100);
      err_total++;
      stop_test();
   end
endmodule : test_fnvc_config_one
bind fnvc_config_one fnvc_config_one_chk fnvc_config_one_chk_inst (.*);
